// ==== tpr_pkg.sv ====
// Operation
// - clock mode 0 double rate, 1 single
// - receive sizing and mode locked while receiving
// - superframe count bits 23-16, reset 0x3
// - timeslots per frame bits 6-0, reset 0x7F
// - writes of six or less store 0x7F
// - transfer engine enable bit 0, reset 0
// - transmit frame tally, 24-bit, read only
// - receive frame tally, 24-bit, read only
// - byte order 0 little, 1 big endian
// - transmit channel bitmap state, twelve channels
// - receive channel bitmap state, twelve channels
// - urgency level and ceiling, reset 0x7
// - ceiling above level treated as equal
// - receive serial enable stops or runs receiver
// - redundancy 0 uses transmit clock selections
package tpr_pkg;
  // bus widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  // register byte offsets
  localparam logic [11:0] OFS_LINK_CONTROL   = 12'h080;
  localparam logic [11:0] OFS_TX_CLOCK_SRC   = 12'h0A0;
  localparam logic [11:0] OFS_RX_CLOCK_SRC   = 12'h0C0;
  localparam logic [11:0] OFS_RX_CONTROL     = 12'h0C4;
  localparam logic [11:0] OFS_RX_SIZING      = 12'h0C8;
  localparam logic [11:0] OFS_UNITS_ENABLE   = 12'h100;
  localparam logic [11:0] OFS_TX_TALLY       = 12'h104;
  localparam logic [11:0] OFS_RX_TALLY       = 12'h108;
  localparam logic [11:0] OFS_BYTE_ORDER     = 12'h10C;
  localparam logic [11:0] OFS_TX_BITMAP      = 12'h110;
  localparam logic [11:0] OFS_RX_BITMAP      = 12'h114;
  localparam logic [11:0] OFS_URGENCY        = 12'h180;
  // field positions
  localparam int unsigned POS_RX_ENABLE      = 1;
  localparam int unsigned POS_REDUNDANCY     = 4;
  localparam int unsigned POS_FRAMES_LO      = 16;
  localparam int unsigned POS_CEILING_LO     = 4;
  // field widths
  localparam int unsigned TALLY_W            = 24;
  localparam int unsigned BITMAP_W           = 12;
  // reset values
  localparam logic [7:0]  RST_FRAMES         = 8'h03;
  localparam logic [6:0]  RST_TIMESLOTS      = 7'h7F;
  localparam logic [6:0]  TIMESLOTS_MIN_RSV  = 7'h06;
  localparam logic [2:0]  RST_URGENCY        = 3'h7;
  localparam logic [23:0] RST_TALLY          = 24'h000000;
  localparam logic [11:0] RST_BITMAP         = 12'h000;
endpackage : tpr_pkg

// ==== tpr_tally.sv ====
`timescale 1ns/1ps
`default_nettype none
module tpr_tally (
  input  wire logic                        i_mclk,   // register clock
  input  wire logic                        i_nrst,   // async reset, active low
  input  wire logic                        i_frame,  // one-cycle frame pulse
  output var  logic [tpr_pkg::TALLY_W-1:0] o_count   // free-running count
);
  import tpr_pkg::*;

  // next count wraps at the top naturally
  logic [TALLY_W-1:0] next_count;  // incremented value
  assign next_count = o_count + 24'h000001;

  // free-running frame counter
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_count <= RST_TALLY;
    end else if (i_frame) begin
      o_count <= next_count;
    end
  end
endmodule : tpr_tally
`default_nettype wire

// ==== tpr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module tpr_regs (
  input  wire logic                         i_mclk,                 // register clock, 25 MHz
  input  wire logic                         i_nrst,                 // async reset, active low
  input  wire logic                         i_psel,                 // apb select
  input  wire logic                         i_penable,              // apb access phase
  input  wire logic                         i_pwrite,               // apb direction
  input  wire logic [tpr_pkg::ADDR_W-1:0]   i_paddr,                // apb byte address
  input  wire logic [tpr_pkg::DATA_W-1:0]   i_pwdata,               // apb write data
  output var  logic [tpr_pkg::DATA_W-1:0]   o_prdata,               // apb read data
  output logic                              o_pready,               // apb ready
  output logic                              o_pslverr,              // apb error, unmapped
  input  wire logic                         i_tx_frame,             // transmit frame pulse
  input  wire logic                         i_rx_frame,             // receive frame pulse
  input  wire logic [tpr_pkg::BITMAP_W-1:0] i_tx_bitmap_state,      // transmit channel states
  input  wire logic [tpr_pkg::BITMAP_W-1:0] i_rx_bitmap_state,      // receive channel states
  output logic                              o_rx_serial_enable,     // receiver running
  output logic                              o_rx_double_rate,       // receive clock double rate
  output logic                              o_rx_clock_source,      // effective receive source
  output logic [7:0]                        o_rx_frames_per_superframe, // stored count n
  output logic [6:0]                        o_rx_timeslots_per_frame,   // stored size n
  output logic                              o_transfer_engine_enable,   // units running
  output logic                              o_byte_order_select,        // 1 big endian
  output logic [2:0]                        o_transfer_urgency_level,   // priority level
  output logic [2:0]                        o_urgency_ceiling_eff,      // effective ceiling
  output logic                              o_escalation_allowed        // ceiling below level
);
  import tpr_pkg::*;

  // stored control state
  logic                 rx_serial_enable;         // receiver enable
  logic                 clock_redundancy_select;  // 1 dual clock mode
  logic                 tx_clock_source_select;   // transmit source
  logic                 rx_clock_source_select;   // receive source
  logic                 rx_clock_rate_mode;       // 1 single rate
  logic [7:0]           rx_frames_per_superframe; // frames minus one
  logic [6:0]           rx_timeslots_per_frame;   // timeslots minus one
  logic                 transfer_engine_enable;   // units enable
  logic                 byte_order_select;        // endian select
  logic [2:0]           transfer_urgency_level;   // priority
  logic [2:0]           urgency_ceiling;          // max priority
  logic [BITMAP_W-1:0]  tx_bitmap;                // sampled status
  logic [BITMAP_W-1:0]  rx_bitmap;                // sampled status
  logic [TALLY_W-1:0]   tx_tally;                 // transmit frames
  logic [TALLY_W-1:0]   rx_tally;                 // receive frames

  // bus phase decode
  wire setup_rd = i_psel & ~i_penable & ~i_pwrite;  // read setup
  wire access   = i_psel & i_penable;               // access phase
  wire wr       = access & i_pwrite;                // write strobe

  // address decode
  wire hit_link  = (i_paddr == OFS_LINK_CONTROL);
  wire hit_txsrc = (i_paddr == OFS_TX_CLOCK_SRC);
  wire hit_rxsrc = (i_paddr == OFS_RX_CLOCK_SRC);
  wire hit_rxctl = (i_paddr == OFS_RX_CONTROL);
  wire hit_size  = (i_paddr == OFS_RX_SIZING);
  wire hit_units = (i_paddr == OFS_UNITS_ENABLE);
  wire hit_txtal = (i_paddr == OFS_TX_TALLY);
  wire hit_rxtal = (i_paddr == OFS_RX_TALLY);
  wire hit_order = (i_paddr == OFS_BYTE_ORDER);
  wire hit_txbm  = (i_paddr == OFS_TX_BITMAP);
  wire hit_rxbm  = (i_paddr == OFS_RX_BITMAP);
  wire hit_urg   = (i_paddr == OFS_URGENCY);
  wire mapped    = hit_link | hit_txsrc | hit_rxsrc | hit_rxctl | hit_size | hit_units |
                   hit_txtal | hit_rxtal | hit_order | hit_txbm | hit_rxbm | hit_urg;

  wire rx_unlocked = ~rx_serial_enable;

  wire [6:0] wr_size   = i_pwdata[6:0];
  wire       size_rsvd = (wr_size <= TIMESLOTS_MIN_RSV);
  wire [6:0] next_size = size_rsvd ? RST_TIMESLOTS : wr_size;

  // zero-wait slave, error on unmapped access
  assign o_pready  = 1'b1;
  assign o_pslverr = access & ~mapped;

  logic [DATA_W-1:0] next_rdata;  // read word
  always_comb begin
    next_rdata = 32'h00000000;
    case (1'b1)
      hit_link:  next_rdata = {27'h0, clock_redundancy_select, 2'b00, rx_serial_enable, 1'b0};
      hit_txsrc: next_rdata = {31'h0, tx_clock_source_select};
      hit_rxsrc: next_rdata = {31'h0, rx_clock_source_select};
      hit_rxctl: next_rdata = {31'h0, rx_clock_rate_mode};
      hit_size:  next_rdata = {8'h00, rx_frames_per_superframe, 9'h000, rx_timeslots_per_frame};
      hit_units: next_rdata = {31'h0, transfer_engine_enable};
      hit_txtal: next_rdata = {8'h00, tx_tally};
      hit_rxtal: next_rdata = {8'h00, rx_tally};
      hit_order: next_rdata = {31'h0, byte_order_select};
      hit_txbm:  next_rdata = {20'h00000, tx_bitmap};
      hit_rxbm:  next_rdata = {20'h00000, rx_bitmap};
      hit_urg:   next_rdata = {25'h0, urgency_ceiling, 1'b0, transfer_urgency_level};
      default:   next_rdata = 32'h00000000;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= 32'h00000000;
    end else if (setup_rd) begin
      o_prdata <= next_rdata;
    end
  end

  // link and source selections
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_serial_enable        <= 1'b0;
      clock_redundancy_select <= 1'b0;
      tx_clock_source_select  <= 1'b0;
      rx_clock_source_select  <= 1'b0;
    end else if (wr) begin
      if (hit_link) begin
        rx_serial_enable        <= i_pwdata[POS_RX_ENABLE];
        clock_redundancy_select <= i_pwdata[POS_REDUNDANCY];
      end
      if (hit_txsrc) begin
        tx_clock_source_select <= i_pwdata[0];
      end
      if (hit_rxsrc) begin
        rx_clock_source_select <= i_pwdata[0];
      end
    end
  end

  // receive mode and sizing, write protected
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_clock_rate_mode       <= 1'b0;
      rx_frames_per_superframe <= RST_FRAMES;
      rx_timeslots_per_frame   <= RST_TIMESLOTS;
    end else if (wr && rx_unlocked) begin
      if (hit_rxctl) begin
        rx_clock_rate_mode <= i_pwdata[0];
      end
      if (hit_size) begin
        rx_frames_per_superframe <= i_pwdata[POS_FRAMES_LO +: 8];
        rx_timeslots_per_frame   <= next_size;
      end
    end
  end

  // transfer unit controls
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      transfer_engine_enable <= 1'b0;
      byte_order_select      <= 1'b0;
      transfer_urgency_level <= RST_URGENCY;
      urgency_ceiling        <= RST_URGENCY;
    end else if (wr) begin
      if (hit_units) begin
        transfer_engine_enable <= i_pwdata[0];
      end
      if (hit_order) begin
        byte_order_select <= i_pwdata[0];
      end
      if (hit_urg) begin
        transfer_urgency_level <= i_pwdata[2:0];
        urgency_ceiling        <= i_pwdata[POS_CEILING_LO +: 3];
      end
    end
  end

  // status sampled from same-clock channel logic
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_bitmap <= RST_BITMAP;
      rx_bitmap <= RST_BITMAP;
    end else begin
      tx_bitmap <= i_tx_bitmap_state;
      rx_bitmap <= i_rx_bitmap_state;
    end
  end

  tpr_tally u_tx_tally (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_frame (i_tx_frame),
    .o_count (tx_tally)
  );

  tpr_tally u_rx_tally (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_frame (i_rx_frame),
    .o_count (rx_tally)
  );

  wire ceiling_above = (urgency_ceiling > transfer_urgency_level);
  assign o_urgency_ceiling_eff = ceiling_above ? transfer_urgency_level : urgency_ceiling;
  assign o_escalation_allowed  = (urgency_ceiling < transfer_urgency_level);

  assign o_rx_clock_source = clock_redundancy_select ? rx_clock_source_select : tx_clock_source_select;

  assign o_rx_double_rate = ~rx_clock_rate_mode;

  // control outputs straight from registers
  assign o_rx_serial_enable         = rx_serial_enable;
  assign o_rx_frames_per_superframe = rx_frames_per_superframe;
  assign o_rx_timeslots_per_frame   = rx_timeslots_per_frame;
  assign o_transfer_engine_enable   = transfer_engine_enable;
  assign o_byte_order_select        = byte_order_select;
  assign o_transfer_urgency_level   = transfer_urgency_level;
endmodule : tpr_regs
`default_nettype wire

// ==== tpr_regs_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module tpr_regs_sva
  import tpr_pkg::*;
(
  input wire logic              i_mclk,                     // clock
  input wire logic              i_nrst,                     // reset, active low
  input wire logic              i_psel,                     // apb select
  input wire logic              i_penable,                  // apb access
  input wire logic              i_pwrite,                   // apb direction
  input wire logic [ADDR_W-1:0] i_paddr,                    // apb address
  input wire logic [DATA_W-1:0] i_pwdata,                   // apb write data
  input wire logic              o_pslverr,                  // apb error
  input wire logic              o_rx_serial_enable,         // receiver running
  input wire logic              o_rx_double_rate,           // double rate clock
  input wire logic [7:0]        o_rx_frames_per_superframe, // frame count
  input wire logic [6:0]        o_rx_timeslots_per_frame,   // frame size
  input wire logic              o_transfer_engine_enable,   // units running
  input wire logic              o_byte_order_select,        // byte order
  input wire logic [2:0]        o_transfer_urgency_level,   // urgency level
  input wire logic [2:0]        o_urgency_ceiling_eff,      // effective ceiling
  input wire logic              o_escalation_allowed        // escalation flag
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // write access phase at one address
  sequence s_wr(logic [11:0] a);
    i_psel && i_penable && i_pwrite && i_paddr == a;
  endsequence
  // same write with the receiver stopped
  sequence s_wr_open(logic [11:0] a);
    s_wr(a) ##0 !o_rx_serial_enable;
  endsequence
  a_rate_mode: assert property (s_wr_open(OFS_RX_CONTROL) |=> o_rx_double_rate == !$past(i_pwdata[0]))
    else $error("clock mode output wrong");
  a_size_lock: assert property (s_wr(OFS_RX_SIZING) ##0 o_rx_serial_enable |=>
    $stable(o_rx_frames_per_superframe) && $stable(o_rx_timeslots_per_frame)) else $error("locked sizing changed");
  a_frame_count: assert property (s_wr_open(OFS_RX_SIZING) |=> o_rx_frames_per_superframe == $past(i_pwdata[23:16]))
    else $error("frame count not stored");
  a_slot_size: assert property (s_wr_open(OFS_RX_SIZING) |=> o_rx_timeslots_per_frame ==
    (($past(i_pwdata[6:0]) <= 7'h06) ? 7'h7F : $past(i_pwdata[6:0]))) else $error("frame size wrong");
  a_rx_enable: assert property (s_wr(OFS_LINK_CONTROL) |=> o_rx_serial_enable == $past(i_pwdata[1]))
    else $error("receive enable wrong");
  a_engine_bit: assert property (s_wr(OFS_UNITS_ENABLE) |=> o_transfer_engine_enable == $past(i_pwdata[0]))
    else $error("engine enable wrong");
  a_byte_order: assert property (s_wr(OFS_BYTE_ORDER) |=> o_byte_order_select == $past(i_pwdata[0]))
    else $error("byte order wrong");
  a_urgency_eff: assert property (s_wr(OFS_URGENCY) |=> o_transfer_urgency_level == $past(i_pwdata[2:0]) &&
    o_urgency_ceiling_eff == (($past(i_pwdata[6:4]) > $past(i_pwdata[2:0])) ? $past(i_pwdata[2:0]) : $past(i_pwdata[6:4])))
    else $error("urgency fields wrong");
  a_no_escalate: assert property (o_escalation_allowed == (o_urgency_ceiling_eff < o_transfer_urgency_level))
    else $error("escalation flag wrong");
  a_err_phase: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("error outside access phase");
endmodule // tpr_regs_sva
`default_nettype wire

// ==== tpr_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tpr_regs_tb;
  import tpr_pkg::*;
  logic        i_mclk = 1'b0, i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0; // clock, reset, apb
  logic        i_tx_frame = 1'b0, i_rx_frame = 1'b0;                 // frame pulses
  logic [11:0] i_paddr = 12'h000, i_tx_bitmap_state = 12'h000, i_rx_bitmap_state = 12'h000; // address, states
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;                        // write, read, last read data
  logic        o_pready, o_pslverr, o_rx_serial_enable, o_rx_double_rate, o_rx_clock_source, err; // flags
  logic [7:0]  o_rx_frames_per_superframe;                            // frame count
  logic [6:0]  o_rx_timeslots_per_frame;                              // frame size
  logic        o_transfer_engine_enable, o_byte_order_select, o_escalation_allowed; // controls
  logic [2:0]  o_transfer_urgency_level, o_urgency_ceiling_eff;       // urgency
  int          fail_count = 0, compares = 0;                          // tallies
  // free-running clock
  always #20 i_mclk = ~i_mclk;
  tpr_regs u_dut (.i_mclk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .i_tx_frame, .i_rx_frame, .i_tx_bitmap_state, .i_rx_bitmap_state, .o_rx_serial_enable,
    .o_rx_double_rate, .o_rx_clock_source, .o_rx_frames_per_superframe, .o_rx_timeslots_per_frame,
    .o_transfer_engine_enable, .o_byte_order_select, .o_transfer_urgency_level, .o_urgency_ceiling_eff,
    .o_escalation_allowed);
  task automatic close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer, outputs settled on return
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge i_mclk);
      if (o_pready === 1'b1) break;
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n == 8) begin
      fail_count++;
      close_out();
    end
    @(negedge i_mclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic t_reset();
    rchk(OFS_RX_SIZING, 32'h0003007F);
    rchk(OFS_RX_CONTROL, 32'h0);
    rchk(OFS_UNITS_ENABLE, 32'h0);
    rchk(OFS_TX_TALLY, 32'h0);
    rchk(OFS_RX_TALLY, 32'h0);
    rchk(OFS_BYTE_ORDER, 32'h0);
    rchk(OFS_TX_BITMAP, 32'h0);
    rchk(OFS_RX_BITMAP, 32'h0);
    rchk(OFS_URGENCY, 32'h77);
    $display("test reset done");
  endtask
  task automatic t_sizing();
    apb(1'b1, OFS_RX_SIZING, 32'hFFFFFF87);
    rchk(OFS_RX_SIZING, 32'h00FF0007);
    chk({24'h0, o_rx_frames_per_superframe}, 32'hFF);
    chk({25'h0, o_rx_timeslots_per_frame}, 32'h07);
    apb(1'b1, OFS_RX_SIZING, 32'h12340006);
    rchk(OFS_RX_SIZING, 32'h0034007F);
    apb(1'b1, OFS_RX_SIZING, 32'h0); // size of zero stores 0x7F
    rchk(OFS_RX_SIZING, 32'h0000007F);
    chk({25'h0, o_rx_timeslots_per_frame}, 32'h7F);
    $display("test sizing done");
  endtask
  task automatic t_protect();
    apb(1'b1, OFS_LINK_CONTROL, 32'h2);
    rchk(OFS_LINK_CONTROL, 32'h2);
    chk({31'h0, o_rx_serial_enable}, 32'h1);
    apb(1'b1, OFS_RX_SIZING, 32'h00100010);
    rchk(OFS_RX_SIZING, 32'h0000007F);
    apb(1'b1, OFS_RX_CONTROL, 32'h1);
    rchk(OFS_RX_CONTROL, 32'h0);
    chk({31'h0, o_rx_double_rate}, 32'h1);
    apb(1'b1, OFS_LINK_CONTROL, 32'h0);
    chk({31'h0, o_rx_serial_enable}, 32'h0);
    apb(1'b1, OFS_RX_CONTROL, 32'h1); // receiver stopped, mode write accepted
    rchk(OFS_RX_CONTROL, 32'h1);
    chk({31'h0, o_rx_double_rate}, 32'h0);
    $display("test protect done");
  endtask
  task automatic t_units();
    apb(1'b1, OFS_UNITS_ENABLE, 32'hFFFFFFFF);
    rchk(OFS_UNITS_ENABLE, 32'h1);
    chk({31'h0, o_transfer_engine_enable}, 32'h1);
    apb(1'b1, OFS_BYTE_ORDER, 32'hFFFFFFFF);
    rchk(OFS_BYTE_ORDER, 32'h1);
    chk({31'h0, o_byte_order_select}, 32'h1);
    apb(1'b1, OFS_UNITS_ENABLE, 32'h0);
    chk({31'h0, o_transfer_engine_enable}, 32'h0);
    $display("test units done");
  endtask
  task automatic t_status();
    int i;
    for (i = 0; i < 5; i++) begin
      @(posedge i_mclk);
      i_rx_frame <= 1'b1;
      i_tx_frame <= (i < 3);
      @(posedge i_mclk);
      i_rx_frame <= 1'b0;
      i_tx_frame <= 1'b0;
    end
    i_tx_bitmap_state <= 12'h264;
    i_rx_bitmap_state <= 12'h489;
    apb(1'b1, OFS_TX_TALLY, 32'hFFFFFFFF);
    apb(1'b1, OFS_RX_BITMAP, 32'h0);
    rchk(OFS_TX_TALLY, 32'h3);
    rchk(OFS_RX_TALLY, 32'h5);
    rchk(OFS_TX_BITMAP, 32'h264);
    rchk(OFS_RX_BITMAP, 32'h489);
    $display("test status done");
  endtask
  task automatic t_misc();
    apb(1'b1, OFS_URGENCY, 32'hFFFFFF53);
    rchk(OFS_URGENCY, 32'h53);
    chk({29'h0, o_transfer_urgency_level}, 32'h3);
    chk({29'h0, o_urgency_ceiling_eff}, 32'h3);
    chk({31'h0, o_escalation_allowed}, 32'h0);
    apb(1'b1, OFS_URGENCY, 32'h25); // ceiling kept below level
    chk({29'h0, o_transfer_urgency_level}, 32'h5);
    chk({29'h0, o_urgency_ceiling_eff}, 32'h2);
    chk({31'h0, o_escalation_allowed}, 32'h1);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, OFS_TX_CLOCK_SRC, 32'h1);
    apb(1'b1, OFS_RX_CLOCK_SRC, 32'h0);
    chk({31'h0, o_rx_clock_source}, 32'h1);
    apb(1'b1, OFS_LINK_CONTROL, 32'h10);
    chk({31'h0, o_rx_clock_source}, 32'h0);
    $display("test misc done");
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge i_mclk);
    i_nrst <= 1'b1;
    t_reset();
    t_sizing();
    t_protect();
    t_units();
    t_status();
    t_misc();
    close_out();
  end
endmodule // tpr_regs_tb
bind tpr_regs tpr_regs_sva u_sva (.i_mclk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .o_pslverr, .o_rx_serial_enable, .o_rx_double_rate, .o_rx_frames_per_superframe, .o_rx_timeslots_per_frame,
  .o_transfer_engine_enable, .o_byte_order_select, .o_transfer_urgency_level, .o_urgency_ceiling_eff,
  .o_escalation_allowed);
`default_nettype wire
